/* File: verilog/host_port_mode_select.sv */
// Host port mode selector with receive FIFO
// How it works
// R01: Port-select pin low gives 8-bit parallel port, high gives serial port.
// R02: In serial, data line 5 low picks plain SPI, high picks dual/quad.
// R03: In serial, data line 4 low picks two lanes, high four lanes.
// R04: Serial clock comes in on the parallel write strobe pin.
// R05: Serial slave select comes in on the parallel device-enable pin.
// R06: Single SPI takes host data only from data line 0.
// R07: Single SPI drives data to the host on data line 1.
// R08: Dual and quad modes use lines 0 and 1 as two-way lanes.
// R09: Lines 2 and 3 are two-way lanes only in quad modes.
// R10: Parallel mode uses all eight data lines as a two-way byte bus.
// R11: Host qualifies parallel accesses with active-low chip select.
// R12: Host reads with active-low read strobe, writes with active-low write strobe.
// R13: Serial port works in clock mode 0 and mode 3 only.
// R14: A dedicated interrupt output to the host exists in every mode.
// R15: Unused lines 2 and 3 are tied off by the board and ignored.
// R16: Straps are static; routing changes only when the straps change.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module host_port_fifo #(
  parameter int unsigned WIDTH = `HPM_FIFO_WIDTH,
  parameter int unsigned DEPTH = `HPM_FIFO_DEPTH
) (
  // Clock and control
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
    logic                        full;
    logic                        empty;
  } fifo_state_type;

  fifo_state_type s;
  fifo_state_type next_s;
  logic           push;
  logic           pop;

  always_comb begin
    next_s = s;
    push   = in_valid && !s.full;
    pop    = out_ready && !s.empty;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    unique case ({push, pop})
      2'b10: next_s.count = s.count + 1'b1;
      2'b01: next_s.count = s.count - 1'b1;
      2'b00,
      2'b11: next_s.count = s.count;
    endcase
    next_s.full  = (next_s.count == (AW + 1)'(DEPTH));
    next_s.empty = (next_s.count == '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s       <= '0;
      s.empty <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign in_ready  = !s.full;
  assign out_valid = !s.empty;
  assign out_data  = s.mem[s.rd];

endmodule : host_port_fifo

// ----------------------------------------------------------------
// Host port mode selector
// ----------------------------------------------------------------
module host_port_mode_select
  import host_port_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = `HPM_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Host control pins
  input  wire logic       host_port_select,
  input  wire logic       par_chip_sel_n,
  input  wire logic       par_read_n,
  input  wire logic       par_write_n,
  input  wire logic       par_dev_enable_n,
  // Host data lines
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic      [7:0] host_data_oe_n,
  // Host interrupt
  output logic            host_irq_out,
  // Core interrupt request
  input  wire logic       irq_req,
  // Core transmit side
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_taken,
  input  wire logic       io_drive,
  // Core receive side
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  // Status
  input  wire logic       overrun_clear,
  output logic            rx_overrun,
  output mode_type        port_mode
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic mode_type decode_mode(input pin_bus_type p);
    mode_type m;
    m = mode_parallel;
    // R01: port select strap
    if (p.port_sel) begin
      // R02: family strap
      if (!p.data[`HPM_FAMILY_LINE]) begin
        m = mode_spi;
      // R03: width strap
      end else if (!p.data[`HPM_WIDTH_LINE]) begin
        m = mode_dual;
      end else begin
        m = mode_quad;
      end
    end
    return m;
  endfunction : decode_mode

  function automatic logic [3:0] lane_bits(input mode_type m);
    logic [3:0] b;
    b = `HPM_LANES_SPI;
    unique case (m)
      mode_parallel: b = `HPM_LANES_SPI;
      mode_spi:      b = `HPM_LANES_SPI;
      mode_dual:     b = `HPM_LANES_DUAL;
      mode_quad:     b = `HPM_LANES_QUAD;
    endcase
    return b;
  endfunction : lane_bits

  function automatic logic [7:0] lane_mask(input logic [3:0] nb);
    return (8'h01 << nb) - 8'h01;
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  port_state_type s;
  port_state_type next_s;
  pin_bus_type    raw;
  logic           fifo_in_ready;
  logic [3:0]     nb;
  logic [3:0]     sum;
  logic [7:0]     rx_next;
  logic [7:0]     byte_val;
  logic           new_byte;
  logic           active;
  logic           rise;
  logic           fall;
  logic           rd_fall;

  // R04: serial clock shares the write strobe pin
  // R05: slave select shares the device-enable pin
  assign raw = '{
    port_sel:     host_port_select,
    chip_sel_n:   par_chip_sel_n,
    read_n:       par_read_n,
    write_n:      par_write_n,
    dev_enable_n: par_dev_enable_n,
    data:         host_data_in
  };

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s   = s;
    nb       = lane_bits(s.mode);
    sum      = 4'h0;
    rx_next  = s.rx_shift;
    byte_val = `HPM_ZERO_BYTE;
    new_byte = 1'b0;
    active   = 1'b0;
    rise     = s.pins.write_n && !s.prev.write_n;
    fall     = !s.pins.write_n && s.prev.write_n;
    rd_fall  = !s.pins.read_n && s.prev.read_n;

    // Pins are only read after the second stage
    next_s.meta     = raw;
    next_s.pins     = s.meta;
    next_s.prev     = s.pins;
    next_s.tx_taken = 1'b0;
    // R14: interrupt passes in every mode
    next_s.irq      = irq_req;

    // R16: straps take effect only while deselected
    if (s.pins.dev_enable_n) begin
      next_s.mode = decode_mode(s.pins);
    end

    if (s.push_valid && fifo_in_ready) begin
      next_s.push_valid = 1'b0;
    end

    next_s.data_oe_n = `HPM_OE_ALL_OFF;

    if (s.mode == mode_parallel) begin
      // R11: chip select and device enable qualify access
      active = !s.pins.chip_sel_n && !s.pins.dev_enable_n;
      // R12: read strobe fetches a byte from the core
      if (active && rd_fall) begin
        next_s.tx_shift = tx_valid ? tx_data : `HPM_IDLE_BYTE;
        next_s.tx_taken = tx_valid;
      end
      // R12: byte is taken as the write strobe ends
      if (active && rise) begin
        new_byte = 1'b1;
        byte_val = s.prev.data;
      end
      // R10: full byte bus driven during reads
      next_s.data_out = next_s.tx_shift;
      if (active && !s.pins.read_n) begin
        next_s.data_oe_n = `HPM_ZERO_BYTE;
      end
    end else begin
      active = !s.pins.dev_enable_n;
      if (s.prev.dev_enable_n && active) begin
        // First byte is ready before the first clock edge
        next_s.bit_cnt  = 4'h0;
        next_s.sampled  = 1'b0;
        next_s.tx_shift = tx_valid ? tx_data : `HPM_IDLE_BYTE;
        next_s.tx_taken = tx_valid;
      end else if (active && rise) begin
        // R13: sample on the rising edge in both modes
        // R06: single lane reads only line 0
        // R15: lines 2 and 3 fall outside the mask unless quad
        rx_next = (s.rx_shift << nb) | (s.pins.data & lane_mask(nb));
        next_s.rx_shift = rx_next;
        next_s.sampled  = 1'b1;
        sum = s.bit_cnt + nb;
        if (sum == `HPM_BYTE_BITS) begin
          next_s.bit_cnt = 4'h0;
          new_byte       = 1'b1;
          byte_val       = rx_next;
        end else begin
          next_s.bit_cnt = sum;
        end
      end else if (active && fall && s.sampled) begin
        // R13: shift on falling edge; mode 3 idle edge is skipped
        if (s.bit_cnt == 4'h0) begin
          next_s.tx_shift = tx_valid ? tx_data : `HPM_IDLE_BYTE;
          next_s.tx_taken = tx_valid;
        end else begin
          next_s.tx_shift = s.tx_shift << nb;
        end
      end

      next_s.data_out = `HPM_ZERO_BYTE;
      if (s.mode == mode_spi) begin
        // R07: single lane drives line 1
        next_s.data_out[`HPM_SO_LINE] = next_s.tx_shift[7];
        if (active) begin
          next_s.data_oe_n[`HPM_SO_LINE] = 1'b0;
        end
      end else begin
        // R08: the lanes in use carry the top bits, highest bit on the highest lane
        // R09: lanes 2 and 3 join in quad only
        next_s.data_out = (next_s.tx_shift >> (`HPM_BYTE_BITS - nb)) & lane_mask(nb);
        if (active && io_drive) begin
          next_s.data_oe_n = `HPM_OE_ALL_OFF & ~lane_mask(nb);
        end
      end
    end

    // Clear first so that a new overrun in the same cycle wins
    if (overrun_clear) begin
      next_s.overrun = 1'b0;
    end
    // A full FIFO holds the pending byte; a further one overruns
    if (new_byte) begin
      if (next_s.push_valid) begin
        next_s.overrun = 1'b1;
      end else begin
        next_s.push_valid = 1'b1;
        next_s.push_data  = byte_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s           <= '0;
      s.meta      <= '1;
      s.pins      <= '1;
      s.prev      <= '1;
      // Strap stages start at parallel, else a false serial mode shows after reset
      s.meta.port_sel <= 1'b0;
      s.pins.port_sel <= 1'b0;
      s.mode      <= mode_parallel;
      s.tx_shift  <= `HPM_IDLE_BYTE;
      s.data_oe_n <= `HPM_OE_ALL_OFF;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  host_port_fifo #(
    .WIDTH (`HPM_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_data   (s.push_data),
    .in_valid  (s.push_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_data_out  = s.data_out;
  assign host_data_oe_n = s.data_oe_n;
  assign host_irq_out   = s.irq;
  assign tx_taken       = s.tx_taken;
  assign rx_overrun     = s.overrun;
  assign port_mode      = s.mode;

endmodule : host_port_mode_select

`default_nettype wire

/* File: verilog/host_port_cfg.svh */
// Constants for the host port mode selector
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// Widths and depths
`define HPM_DATA_W      8
`define HPM_FIFO_DEPTH  32
`define HPM_FIFO_WIDTH  8

// Strap positions on the data lines
`define HPM_WIDTH_LINE  4
`define HPM_FAMILY_LINE 5

// Serial lane positions
`define HPM_SI_LINE     0
`define HPM_SO_LINE     1

// Reset and idle values, byte size and lane counts
`define HPM_OE_ALL_OFF  8'hff
`define HPM_IDLE_BYTE   8'hff
`define HPM_ZERO_BYTE   8'h00
`define HPM_BYTE_BITS   4'h8
`define HPM_LANES_SPI   4'h1
`define HPM_LANES_DUAL  4'h2
`define HPM_LANES_QUAD  4'h4

`endif

/* File: verilog/host_port_pkg.sv */
// Types shared by the host port mode selector
`include "host_port_cfg.svh"

package host_port_pkg;

  // Port configuration, Gray coded along parallel-spi-dual-quad
  typedef enum logic [1:0] {
    mode_parallel = 2'b00,
    mode_spi      = 2'b01,
    mode_dual     = 2'b11,
    mode_quad     = 2'b10
  } mode_type;

  // One sample of the host pins
  typedef struct packed {
    logic       port_sel;
    logic       chip_sel_n;
    logic       read_n;
    logic       write_n;
    logic       dev_enable_n;
    logic [7:0] data;
  } pin_bus_type;

  // Whole state of the selector
  typedef struct packed {
    pin_bus_type meta;
    pin_bus_type pins;
    pin_bus_type prev;
    mode_type    mode;
    logic        sampled;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic [7:0]  data_out;
    logic [7:0]  data_oe_n;
    logic        push_valid;
    logic [7:0]  push_data;
    logic        overrun;
    logic        tx_taken;
    logic        irq;
  } port_state_type;

endpackage : host_port_pkg

/* File: testbench/host_port_monitor.sv */
// Checker for the host port mode selector
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor
  import host_port_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ce,
  // Host pins
  input wire logic       par_chip_sel_n,
  input wire logic       par_read_n,
  input wire logic       par_dev_enable_n,
  input wire logic [7:0] host_data_oe_n,
  input wire logic       host_irq_out,
  // Core side
  input wire logic       irq_req,
  input wire logic       tx_taken,
  input wire logic       rx_valid,
  input wire logic       rx_overrun,
  input wire mode_type   port_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Host access sequences
  // ----------------------------------------
  // Six cycles covers the pin synchronisers plus the output register
  sequence read_held;
    (ce && port_mode == mode_parallel && !par_read_n && !par_chip_sel_n && !par_dev_enable_n) [*6];
  endsequence
  sequence bus_idle_held;
    (ce && port_mode == mode_parallel && (par_read_n || par_chip_sel_n)) [*6];
  endsequence
  sequence serial_sel_held;
    (ce && port_mode == mode_spi && !par_dev_enable_n) [*6];
  endsequence
  sequence serial_desel_held;
    (ce && port_mode != mode_parallel && par_dev_enable_n) [*6];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // reset state
  reset_state_a: assert property ($fell(rst) && $past(ce) |-> host_data_oe_n == 8'hff && !rx_valid && !rx_overrun && port_mode == mode_parallel)
    else $error("wrong state after reset");
  irq_follow_a: assert property (ce |=> host_irq_out == $past(irq_req))
    else $error("interrupt output does not follow request");
  read_drive_a: assert property (read_held |-> host_data_oe_n == 8'h00)
    else $error("parallel read not driven");
  bus_release_a: assert property (bus_idle_held |-> host_data_oe_n == 8'hff)
    else $error("bus driven without qualified read");
  spi_out_a: assert property (serial_sel_held |-> !host_data_oe_n[1])
    else $error("serial output line not driven");
  spi_lines_a: assert property (port_mode == mode_spi |-> host_data_oe_n[0] && &host_data_oe_n[7:2])
    else $error("single serial drives a wrong line");
  upper_lanes_a: assert property (port_mode inside {mode_spi, mode_dual} |-> &host_data_oe_n[3:2])
    else $error("lines 2 and 3 driven outside quad");
  strap_lines_a: assert property (port_mode != mode_parallel |-> &host_data_oe_n[7:4])
    else $error("upper lines driven in serial mode");
  desel_idle_a: assert property (serial_desel_held |-> host_data_oe_n == 8'hff)
    else $error("lines driven while deselected");
  tx_pulse_a: assert property (tx_taken |=> !tx_taken)
    else $error("load pulse longer than one cycle");
endmodule : host_port_monitor

bind host_port_mode_select host_port_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_mon (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .par_chip_sel_n(par_chip_sel_n), .par_read_n(par_read_n),
  .par_dev_enable_n(par_dev_enable_n), .host_data_oe_n(host_data_oe_n), .host_irq_out(host_irq_out),
  .irq_req(irq_req), .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_overrun(rx_overrun), .port_mode(port_mode));
`default_nettype wire

/* File: testbench/host_mcu_model.sv */
// Host microcontroller model for the host port pins
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  // Resolved data lines
  input wire logic [7:0] lines,
  // Pins driven by the host
  output logic       port_sel,
  output logic       cs_n,
  output logic       rd_n,
  output logic       wr_n,
  output logic       de_n,
  output logic [7:0] drv,
  output logic [7:0] en
);
  initial begin
    port_sel = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    de_n = 1'b1;
    drv = 8'h00;
    en = 8'hff;
  end
  // static straps, lines 2 and 3 tied
  task automatic strap(input logic sel, input logic [1:0] fw);
    port_sel = sel;
    // Strobe idles high while deselected, so a later parallel access sees no false write
    wr_n = 1'b1;
    drv = {2'b00, fw, 4'b1000};
    en = 8'hff;
    #200;
  endtask : strap
  task automatic par_cycle(input logic wr, input logic cs, input logic [7:0] d, output logic [7:0] q);
    drv = d;
    en = {8{wr}};
    cs_n = !cs;
    de_n = 1'b0;
    #40;
    wr_n = !wr;
    rd_n = wr;
    #60;
    q = lines;
    wr_n = 1'b1;
    rd_n = 1'b1;
    #40;
    cs_n = 1'b1;
    de_n = 1'b1;
    en = 8'hff;
    #40;
  endtask : par_cycle
  // clock modes 0 and 3, clock still outside frames
  task automatic ser_frame(input int lanes, input logic cpol, input logic [7:0] d, output logic [7:0] q);
    logic [3:0] m;
    m = 4'((1 << lanes) - 1);
    wr_n = cpol;
    en = (lanes == 1) ? 8'hfd : 8'hff;
    de_n = 1'b0;
    #100;
    for (int i = 8 - lanes; i >= 0; i -= lanes) begin
      wr_n = 1'b0;
      // lanes, high bit on highest line
      drv[3:0] = (drv[3:0] & ~m) | (4'(d >> i) & m);
      #62.5;
      q = {q[6:0], lines[1]};
      wr_n = 1'b1;
      #62.5;
    end
    wr_n = cpol;
    #62.5;
    de_n = 1'b1;
    en = 8'hff;
    #100;
  endtask : ser_frame
endmodule : host_mcu_model
`default_nettype wire

/* File: testbench/host_port_mode_select_tb.sv */
// Self-checking bench for the host port mode selector
`timescale 1ns/1ps
`default_nettype none
module host_port_mode_select_tb
  import host_port_pkg::*;
;
  typedef struct packed {
    logic       sel;
    logic [1:0] fw;
    mode_type   m;
    logic [2:0] lanes;
    logic       cpol;
    logic [7:0] b;
  } row_type;
  logic       clk_sys, rst, ce, irq_req, tx_valid, tx_taken, io_drive, rx_valid, rx_ready;
  logic       overrun_clear, rx_overrun, host_irq_out, port_sel, cs_n, rd_n, wr_n, de_n;
  logic [7:0] drv, en, lines, host_data_out, host_data_oe_n, tx_data, rx_data, q;
  mode_type   port_mode;
  int         bad_count = 0, n_tests = 0, tx_seen = 0, n;
  row_type    rows [5] = '{'{1'b0, 2'b11, mode_parallel, 3'd0, 1'b0, 8'h3c},
    '{1'b1, 2'b00, mode_spi, 3'd1, 1'b0, 8'hc3}, '{1'b1, 2'b01, mode_spi, 3'd1, 1'b1, 8'h81},
    '{1'b1, 2'b10, mode_dual, 3'd2, 1'b0, 8'h5e}, '{1'b1, 2'b11, mode_quad, 3'd4, 1'b0, 8'ha7}};
  // Released lines show the inverse of the device's current output value
  assign lines = (~host_data_oe_n & host_data_out) | (host_data_oe_n & en & drv)
    | (host_data_oe_n & ~en & ~host_data_out);
  host_port_mode_select #(.FIFO_DEPTH(4)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .host_port_select(port_sel), .par_chip_sel_n(cs_n),
    .par_read_n(rd_n), .par_write_n(wr_n), .par_dev_enable_n(de_n), .host_data_in(lines),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n), .host_irq_out(host_irq_out),
    .irq_req(irq_req), .tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(tx_taken), .io_drive(io_drive),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .overrun_clear(overrun_clear),
    .rx_overrun(rx_overrun), .port_mode(port_mode));
  host_mcu_model i_host (.lines(lines), .port_sel(port_sel), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .de_n(de_n), .drv(drv), .en(en));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (tx_taken === 1'b1) tx_seen <= tx_seen + 1;
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Bounded wait for the receive head, then pop it
  task automatic pop(input logic [7:0] exp);
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    if (k == 50) begin
      bad_count++;
      test_done();
    end
    check(rx_data, exp);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
    cyc(2);
  endtask : pop
  initial begin
    {rst, ce, tx_valid} = 3'b111;
    {irq_req, io_drive, rx_ready, overrun_clear} = 4'b0000;
    tx_data = 8'h96;
    cyc(16);
    rst = 1'b0;
    cyc(4);
    check(host_data_oe_n, 8'hff);
    for (int r = 0; r < 5; r++) begin
      i_host.strap(rows[r].sel, rows[r].fw);
      check(8'(port_mode), 8'(rows[r].m));
      if (rows[r].sel) i_host.ser_frame(int'(rows[r].lanes), rows[r].cpol, rows[r].b, q);
      else i_host.par_cycle(1'b1, 1'b1, rows[r].b, q);
      pop(rows[r].b);
      if (rows[r].m == mode_spi) check(q, 8'h96);
    end
    // Parallel read returns the offered byte once
    i_host.strap(1'b0, 2'b00);
    tx_data = 8'ha5;
    n = tx_seen;
    i_host.par_cycle(1'b0, 1'b1, 8'h00, q);
    check(q, 8'ha5);
    check(8'(tx_seen - n), 8'h01);
    // Chip select high refuses the write
    i_host.par_cycle(1'b1, 1'b0, 8'h77, q);
    cyc(10);
    check({7'h00, rx_valid}, 8'h00);
    // Fill past depth with the core stalled: one held, one lost
    for (int k = 0; k < 6; k++) i_host.par_cycle(1'b1, 1'b1, 8'h10 + 8'(k), q);
    check({7'h00, rx_overrun}, 8'h01);
    for (int k = 0; k < 5; k++) pop(8'h10 + 8'(k));
    check({7'h00, rx_valid}, 8'h00);
    overrun_clear = 1'b1;
    cyc(1);
    overrun_clear = 1'b0;
    cyc(1);
    check({7'h00, rx_overrun}, 8'h00);
    irq_req = 1'b1;
    cyc(2);
    check({7'h00, host_irq_out}, 8'h01);
    irq_req = 1'b0;
    cyc(2);
    check({7'h00, host_irq_out}, 8'h00);
    // Reset in mid-run while strapped for quad, then straps re-read
    i_host.strap(1'b1, 2'b11);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    check(8'(port_mode), 8'(mode_parallel));
    cyc(6);
    check(8'(port_mode), 8'(mode_quad));
    // Quad frame in an output phase: the device drives lanes 3 to 0, high nibble first
    io_drive = 1'b1;
    i_host.ser_frame(4, 1'b0, 8'h00, q);
    check({6'h00, q[1:0]}, 8'h02);
    pop(8'ha5);
    io_drive = 1'b0;
    test_done();
  end
endmodule : host_port_mode_select_tb
`default_nettype wire
